// >>> rtl/iaoc_consts.svh
// offsets, field positions, reset values and codes of the aux interlock block
`ifndef IAOC_CONSTS_SVH
`define IAOC_CONSTS_SVH

// register word indexes (byte address = index * 4)
`define IAOC_IDX_A_CFG 6'h00
`define IAOC_IDX_A_SPEED 6'h01
`define IAOC_IDX_A_GEAR 6'h02
`define IAOC_IDX_B_CFG 6'h03
`define IAOC_IDX_B_SPEED 6'h04
`define IAOC_IDX_B_GEAR 6'h05
`define IAOC_IDX_FEAT 6'h06
`define IAOC_IDX_STATUS 6'h07

// cfg register fields
`define IAOC_CFG_SEL_LSB 0
`define IAOC_CFG_SEL_MSB 4
`define IAOC_CFG_LATCH_BIT 8
// feature register fields
`define IAOC_FEAT_PTO_BIT 0
`define IAOC_FEAT_AT_BIT 1
// status field base positions
`define IAOC_ST_OUT_LSB 0
`define IAOC_ST_LATCH_LSB 2
`define IAOC_ST_PIN_LSB 4
// address decode and value fields
`define IAOC_ADDR_HI_LSB 8
`define IAOC_ADDR_IDX_MSB 7
`define IAOC_ADDR_IDX_LSB 2
`define IAOC_VAL_MSB 7
`define IAOC_FEAT_MSB 1

// reset values
`define IAOC_RST_SEL 5'h00
`define IAOC_RST_SPEED 8'h00
`define IAOC_RST_GEAR 8'h7D
`define IAOC_RST_FEAT 2'h0

// gear coding: neutral, forward above it, reverse below it
`define IAOC_GEAR_NEUTRAL 8'h7D
`define IAOC_SPEED_STOPPED 8'h00

`define IAOC_HTRANS_NONSEQ 2'h2
`define IAOC_HSIZE_WORD 3'h2
`define IAOC_HRESP_OKAY 1'h0
`define IAOC_SYNC_W 6

`endif

// >>> rtl/iaoc_pkg.sv
// types shared by the aux interlock block
`default_nettype none
package iaoc_pkg;

  typedef enum logic [4:0] {
    IAOC_SEL_NONE = 5'h00, IAOC_SEL_PARK_ON = 5'h01, IAOC_SEL_PARK_OFF = 5'h02,
    IAOC_SEL_DOOR_OPEN = 5'h03, IAOC_SEL_DOOR_SHUT = 5'h04,
    IAOC_SEL_PTO_ON = 5'h05, IAOC_SEL_PTO_OFF = 5'h06,
    IAOC_SEL_ENG_ON = 5'h07, IAOC_SEL_ENG_OFF = 5'h08,
    IAOC_SEL_SPD_ABOVE = 5'h09, IAOC_SEL_SPD_BELOW = 5'h0A,
    IAOC_SEL_STOPPED = 5'h0B, IAOC_SEL_MOVING = 5'h0C,
    IAOC_SEL_GEAR_ABOVE = 5'h0D, IAOC_SEL_GEAR_BELOW = 5'h0E,
    IAOC_SEL_NEUTRAL = 5'h0F, IAOC_SEL_NOT_NEUTRAL = 5'h10
  } iaoc_sel_t;

  typedef struct packed {
    logic park;
    logic door;
    logic pto;
    logic engine;
    logic [7:0] speed;
    logic [7:0] gear;
  } iaoc_veh_t;

endpackage
`default_nettype wire

// >>> rtl/iaoc_chan_if.sv
// signals between the register/condition logic and one output channel
`timescale 1ns/1ps
`default_nettype none
interface iaoc_chan_if;
  logic sw;
  logic cond;
  logic latch_en;
  logic out;
  logic latched;
  modport ctrl (output sw, output cond, output latch_en, input out, input latched);
  modport chan (input sw, input cond, input latch_en, output out, output latched);
endinterface
`default_nettype wire

// >>> rtl/iaoc_channel.sv
// output stage of one aux channel: qualification and latch-off
`timescale 1ns/1ps
`default_nettype none
module iaoc_channel (
  input wire logic hclk,
  input wire logic hresetn,
  iaoc_chan_if.chan ch
);
  logic out_q;
  logic latched_q;
  logic drop;

  assign drop = out_q & ch.sw & ~ch.cond;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_q <= 1'b0;
    end else if (!ch.latch_en || !ch.sw) begin
      latched_q <= 1'b0;
    end else if (drop) begin
      latched_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= 1'b0;
    end else begin
      out_q <= ch.sw & ch.cond & ~latched_q;
    end
  end

  assign ch.out = out_q;
  assign ch.latched = latched_q;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  reenable_out_a: assert property (
    (!ch.latch_en && ch.sw && ch.cond) |=> out_q)
    else $error("output not restored with latch-off clear");
  latch_hold_a: assert property (
    (ch.latch_en && out_q && ch.sw && !ch.cond) |=> (!out_q && latched_q)
      ##1 (!(ch.latch_en && ch.sw) || !out_q))
    else $error("latched output came back on");
  latched_off_a: assert property (
    latched_q |-> ##1 !out_q)
    else $error("latched channel drove its output");
  latch_release_a: assert property (
    (latched_q && !ch.sw) |=> !latched_q)
    else $error("latch not released by switch-off");

  latch_cycle_c: cover property (latched_q ##1 !ch.sw ##1 ch.sw ##1 out_q);
endmodule
`default_nettype wire

// >>> rtl/iaoc_top.sv
// two interlocked aux outputs with an AHB-Lite register slave
// Notes on behaviour
// - Selector 0 passes the switch straight to the output.
// - Selector 1 needs park brake set, 2 needs it released, with the switch on.
// - Selector 3 needs a door open, 4 needs all doors closed, with the switch on.
// - Selector 5 needs the PTO engaged, 6 not engaged, switch on, PTO fitted.
// - Selector 7 needs the engine running, 8 not running, with the switch on.
// - Selector 9 needs speed above the threshold, 10 below it, with the switch on.
// - Selector 11 needs the vehicle stopped, 12 moving, with the switch on.
// - Selector 13 needs gear above the threshold, 14 below, switch on, automatic.
// - Selector 15 needs neutral, 16 not neutral, switch on, automatic fitted.
// - Without latch-off a dropped output returns when the condition returns.
// - With latch-off a dropped output stays off even with the switch still on.
// - The speed threshold is consulted only for selectors 9 and 10.
// - The gear threshold is consulted only for selectors 13 and 14.
// - Gear code 125 is neutral and 125 plus n the nth forward gear.
// - Gear code 125 minus n is the nth reverse gear.
// - Each channel has its own selector choosing its condition.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iaoc_consts.svh"
module iaoc_top
  import iaoc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic aux_a_switch,
  input wire logic aux_b_switch,
  input wire logic park_brake_set,
  input wire logic door_open,
  input wire logic pto_engaged,
  input wire logic engine_running,
  input wire logic [7:0] vehicle_speed,
  input wire logic [7:0] trans_gear,
  output logic aux_a_out,
  output logic aux_b_out
);

  //////////////////////////////////////////////////////////////////////////
  // condition evaluation, shared by both channels
  function automatic logic iaoc_cond(input logic [4:0] sel, input logic [7:0] spd_thr,
                                     input logic [7:0] gear_thr, input iaoc_veh_t v,
                                     input logic pto_fit, input logic at_fit);
    logic r;
    r = 1'b0;
    unique case (iaoc_sel_t'(sel))
      IAOC_SEL_NONE: r = 1'b1;
      IAOC_SEL_PARK_ON: r = v.park;
      IAOC_SEL_PARK_OFF: r = !v.park;
      IAOC_SEL_DOOR_OPEN: r = v.door;
      IAOC_SEL_DOOR_SHUT: r = !v.door;
      IAOC_SEL_PTO_ON: r = pto_fit && v.pto;
      IAOC_SEL_PTO_OFF: r = pto_fit && !v.pto;
      IAOC_SEL_ENG_ON: r = v.engine;
      IAOC_SEL_ENG_OFF: r = !v.engine;
      IAOC_SEL_SPD_ABOVE: r = v.speed > spd_thr;
      IAOC_SEL_SPD_BELOW: r = v.speed < spd_thr;
      IAOC_SEL_STOPPED: r = v.speed == `IAOC_SPEED_STOPPED;
      IAOC_SEL_MOVING: r = v.speed != `IAOC_SPEED_STOPPED;
      IAOC_SEL_GEAR_ABOVE: r = at_fit && (v.gear > gear_thr);
      IAOC_SEL_GEAR_BELOW: r = at_fit && (v.gear < gear_thr);
      IAOC_SEL_NEUTRAL: r = at_fit && (v.gear == `IAOC_GEAR_NEUTRAL);
      IAOC_SEL_NOT_NEUTRAL: r = at_fit && (v.gear != `IAOC_GEAR_NEUTRAL);
      // unassigned selector codes keep the output off
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, accept when stages two and three agree
  logic [`IAOC_SYNC_W-1:0] pin_raw;
  logic [`IAOC_SYNC_W-1:0] s1_q;
  logic [`IAOC_SYNC_W-1:0] s2_q;
  logic [`IAOC_SYNC_W-1:0] s3_q;
  logic [`IAOC_SYNC_W-1:0] pin_q;

  assign pin_raw = {engine_running, pto_engaged, door_open, park_brake_set,
                    aux_b_switch, aux_a_switch};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= '0;
    end else begin
      for (int i = 0; i < `IAOC_SYNC_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  logic wr_pend_q;
  logic [5:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic take;
  logic rd_take;

  assign addr_ok = (haddr[31:`IAOC_ADDR_HI_LSB] == '0) &&
                   (haddr[`IAOC_ADDR_IDX_LSB-1:0] == '0);
  assign take = hsel && hready && (htrans == `IAOC_HTRANS_NONSEQ);
  assign rd_take = take && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= `IAOC_IDX_A_CFG;
    end else begin
      wr_pend_q <= take && hwrite && addr_ok && (hsize == `IAOC_HSIZE_WORD);
      wr_idx_q <= haddr[`IAOC_ADDR_IDX_MSB:`IAOC_ADDR_IDX_LSB];
    end
  end

  logic [4:0] sel_a_q;
  logic [4:0] sel_b_q;
  logic latch_a_q;
  logic latch_b_q;
  logic [7:0] spd_a_q;
  logic [7:0] spd_b_q;
  logic [7:0] gear_a_q;
  logic [7:0] gear_b_q;
  logic [1:0] feat_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_a_q <= `IAOC_RST_SEL;
      sel_b_q <= `IAOC_RST_SEL;
      latch_a_q <= 1'b0;
      latch_b_q <= 1'b0;
      spd_a_q <= `IAOC_RST_SPEED;
      spd_b_q <= `IAOC_RST_SPEED;
      gear_a_q <= `IAOC_RST_GEAR;
      gear_b_q <= `IAOC_RST_GEAR;
      feat_q <= `IAOC_RST_FEAT;
    end else if (wr_pend_q) begin
      unique case (wr_idx_q)
        `IAOC_IDX_A_CFG: begin
          sel_a_q <= hwdata[`IAOC_CFG_SEL_MSB:`IAOC_CFG_SEL_LSB];
          latch_a_q <= hwdata[`IAOC_CFG_LATCH_BIT];
        end
        `IAOC_IDX_B_CFG: begin
          sel_b_q <= hwdata[`IAOC_CFG_SEL_MSB:`IAOC_CFG_SEL_LSB];
          latch_b_q <= hwdata[`IAOC_CFG_LATCH_BIT];
        end
        `IAOC_IDX_A_SPEED: spd_a_q <= hwdata[`IAOC_VAL_MSB:0];
        `IAOC_IDX_B_SPEED: spd_b_q <= hwdata[`IAOC_VAL_MSB:0];
        `IAOC_IDX_A_GEAR: gear_a_q <= hwdata[`IAOC_VAL_MSB:0];
        `IAOC_IDX_B_GEAR: gear_b_q <= hwdata[`IAOC_VAL_MSB:0];
        `IAOC_IDX_FEAT: feat_q <= hwdata[`IAOC_FEAT_MSB:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channels
  iaoc_chan_if ch_a ();
  iaoc_chan_if ch_b ();
  iaoc_veh_t veh;

  assign veh = '{park: pin_q[2], door: pin_q[3], pto: pin_q[4], engine: pin_q[5],
                 speed: vehicle_speed, gear: trans_gear};

  assign ch_a.sw = pin_q[0];
  assign ch_a.latch_en = latch_a_q;
  assign ch_a.cond = iaoc_cond(sel_a_q, spd_a_q, gear_a_q, veh,
                               feat_q[`IAOC_FEAT_PTO_BIT], feat_q[`IAOC_FEAT_AT_BIT]);
  assign ch_b.sw = pin_q[1];
  assign ch_b.latch_en = latch_b_q;
  assign ch_b.cond = iaoc_cond(sel_b_q, spd_b_q, gear_b_q, veh,
                               feat_q[`IAOC_FEAT_PTO_BIT], feat_q[`IAOC_FEAT_AT_BIT]);

  iaoc_channel u_chan_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .ch(ch_a.chan)
  );

  iaoc_channel u_chan_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .ch(ch_b.chan)
  );

  //////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    rd_mux = '0;
    unique case (haddr[`IAOC_ADDR_IDX_MSB:`IAOC_ADDR_IDX_LSB])
      `IAOC_IDX_A_CFG: begin
        rd_mux[`IAOC_CFG_SEL_MSB:`IAOC_CFG_SEL_LSB] = sel_a_q;
        rd_mux[`IAOC_CFG_LATCH_BIT] = latch_a_q;
      end
      `IAOC_IDX_B_CFG: begin
        rd_mux[`IAOC_CFG_SEL_MSB:`IAOC_CFG_SEL_LSB] = sel_b_q;
        rd_mux[`IAOC_CFG_LATCH_BIT] = latch_b_q;
      end
      `IAOC_IDX_A_SPEED: rd_mux[`IAOC_VAL_MSB:0] = spd_a_q;
      `IAOC_IDX_B_SPEED: rd_mux[`IAOC_VAL_MSB:0] = spd_b_q;
      `IAOC_IDX_A_GEAR: rd_mux[`IAOC_VAL_MSB:0] = gear_a_q;
      `IAOC_IDX_B_GEAR: rd_mux[`IAOC_VAL_MSB:0] = gear_b_q;
      `IAOC_IDX_FEAT: rd_mux[`IAOC_FEAT_MSB:0] = feat_q;
      `IAOC_IDX_STATUS: begin
        rd_mux[`IAOC_ST_OUT_LSB +: 2] = {ch_b.out, ch_a.out};
        rd_mux[`IAOC_ST_LATCH_LSB +: 2] = {ch_b.latched, ch_a.latched};
        rd_mux[`IAOC_ST_PIN_LSB +: `IAOC_SYNC_W] = pin_q;
      end
      default: rd_mux = '0;
    endcase
    if (!addr_ok) begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_take) begin
      hrdata_q <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= `IAOC_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `IAOC_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign aux_a_out = ch_a.out;
  assign aux_b_out = ch_b.out;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  no_interlock_a: assert property (
    (sel_a_q == IAOC_SEL_NONE && !latch_a_q) |=> aux_a_out == $past(pin_q[0]))
    else $error("selector 0 did not follow the switch");
  park_brake_a: assert property (
    (sel_b_q == IAOC_SEL_PARK_ON && !latch_b_q) |=> aux_b_out == $past(pin_q[1] && pin_q[2]))
    else $error("park brake interlock wrong");
  speed_above_a: assert property (
    (sel_a_q == IAOC_SEL_SPD_ABOVE && !latch_a_q)
      |=> aux_a_out == $past(pin_q[0] && (vehicle_speed > spd_a_q)))
    else $error("speed interlock wrong");
  neutral_sel_a: assert property (
    (sel_a_q == IAOC_SEL_NEUTRAL && !latch_a_q)
      |=> aux_a_out == $past(pin_q[0] && feat_q[1] && trans_gear == `IAOC_GEAR_NEUTRAL))
    else $error("neutral interlock wrong");
  thr_ignored_a: assert property (
    (sel_a_q == IAOC_SEL_ENG_ON && !latch_a_q)
      |=> aux_a_out == $past(pin_q[0] && pin_q[5]))
    else $error("engine interlock wrong");
  chan_indep_a: assert property (
    (sel_b_q == IAOC_SEL_NONE && !latch_b_q && sel_a_q != IAOC_SEL_NONE)
      |=> aux_b_out == $past(pin_q[1]))
    else $error("channel b disturbed by channel a");
  bus_okay_a: assert property (hreadyout && hresp == `IAOC_HRESP_OKAY)
    else $error("slave not ready or not okay");

  sel0_on_c: cover property (sel_a_q == IAOC_SEL_NONE ##1 aux_a_out);
  gear_on_c: cover property (sel_b_q == IAOC_SEL_GEAR_ABOVE && aux_b_out);
  both_on_c: cover property (aux_a_out && aux_b_out);
endmodule
`default_nettype wire

// >>> bench/iaoc_veh_model.sv
// partner model: cab switches and vehicle status sources feeding the pins
`timescale 1ns/1ps
`default_nettype none
module iaoc_veh_model
  import iaoc_pkg::*;
(
  input wire logic hclk,
  input wire logic sw_a,
  input wire logic sw_b,
  input wire iaoc_veh_t veh,
  output var logic aux_a_switch,
  output var logic aux_b_switch,
  output var logic park_brake_set,
  output var logic door_open,
  output var logic pto_engaged,
  output var logic engine_running,
  output var logic [7:0] vehicle_speed,
  output var logic [7:0] trans_gear
);
  // pins start idle: switches off, vehicle stopped in neutral
  initial {aux_a_switch, aux_b_switch, park_brake_set, door_open, pto_engaged, engine_running,
    vehicle_speed, trans_gear} = {6'h00, 8'h00, 8'h7D};
  // requested state reaches the pins at the next rising edge
  always @(posedge hclk) {aux_a_switch, aux_b_switch, park_brake_set, door_open, pto_engaged,
    engine_running, vehicle_speed, trans_gear} <= {sw_a, sw_b, veh.park, veh.door, veh.pto,
    veh.engine, veh.speed, veh.gear};
endmodule
`default_nettype wire

// >>> bench/tb_interlocked_aux_output_control.sv
// self-checking bench for the interlocked aux output block
`timescale 1ns/1ps
`default_nettype none
`include "iaoc_consts.svh"
module tb_interlocked_aux_output_control
  import iaoc_pkg::*;
  ;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sw_a;
  logic sw_b;
  iaoc_veh_t veh;
  logic aux_a_switch;
  logic aux_b_switch;
  logic park_brake_set;
  logic door_open;
  logic pto_engaged;
  logic engine_running;
  logic [7:0] vehicle_speed;
  logic [7:0] trans_gear;
  logic aux_a_out;
  logic aux_b_out;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [2:0] bus_size = `IAOC_HSIZE_WORD;
  logic [31:0] bus_bias = 32'h00000000;

  iaoc_top u_iaoc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux_a_switch(aux_a_switch),
    .aux_b_switch(aux_b_switch), .park_brake_set(park_brake_set), .door_open(door_open),
    .pto_engaged(pto_engaged), .engine_running(engine_running),
    .vehicle_speed(vehicle_speed), .trans_gear(trans_gear), .aux_a_out(aux_a_out),
    .aux_b_out(aux_b_out));

  iaoc_veh_model u_iaoc_veh_model (.hclk(hclk), .sw_a(sw_a), .sw_b(sw_b), .veh(veh),
    .aux_a_switch(aux_a_switch), .aux_b_switch(aux_b_switch),
    .park_brake_set(park_brake_set), .door_open(door_open), .pto_engaged(pto_engaged),
    .engine_running(engine_running), .vehicle_speed(vehicle_speed), .trans_gear(trans_gear));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer of size bus_size, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'h0} | bus_bias;
    htrans <= `IAOC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= bus_size;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  // pins take five edges to reach the outputs
  task automatic settle();
    repeat (7) @(posedge hclk);
    #1;
  endtask

  function automatic logic exp_on(input logic [4:0] s, input iaoc_veh_t v,
                                  input logic [7:0] ts, input logic [7:0] tg, input logic [1:0] f);
    case (s)
      5'h00: exp_on = 1'b1;
      5'h01: exp_on = v.park;
      5'h02: exp_on = !v.park;
      5'h03: exp_on = v.door;
      5'h04: exp_on = !v.door;
      5'h05: exp_on = v.pto & f[0];
      5'h06: exp_on = !v.pto & f[0];
      5'h07: exp_on = v.engine;
      5'h08: exp_on = !v.engine;
      5'h09: exp_on = v.speed > ts;
      5'h0A: exp_on = v.speed < ts;
      5'h0B: exp_on = v.speed == 8'h00;
      5'h0C: exp_on = v.speed != 8'h00;
      5'h0D: exp_on = (v.gear > tg) & f[1];
      5'h0E: exp_on = (v.gear < tg) & f[1];
      5'h0F: exp_on = (v.gear == 8'h7D) & f[1];
      5'h10: exp_on = (v.gear != 8'h7D) & f[1];
      default: exp_on = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [31:0] rd;
    check("aux_a_out", 32'(aux_a_out), 32'h00000000);
    check("hresp", 32'(hresp), 32'h00000000);
    bus(1'b0, `IAOC_IDX_A_CFG, 32'h00000000, rd);
    check("a_cfg", rd, 32'h00000000);
    bus(1'b0, `IAOC_IDX_A_GEAR, 32'h00000000, rd);
    check("a_gear", rd, 32'h0000007D);
    bus(1'b0, `IAOC_IDX_B_SPEED, 32'h00000000, rd);
    check("b_speed", rd, 32'h00000000);
    bus(1'b0, `IAOC_IDX_FEAT, 32'h00000000, rd);
    check("feat", rd, 32'h00000000);
    wr(6'h08, 32'hFFFFFFFF);
    bus(1'b0, 6'h08, 32'h00000000, rd);
    check("unmapped", rd, 32'h00000000);
  endtask

  // non-word writes and off-map addresses are ignored and read as zero
  task automatic t_refused();
    logic [31:0] rd;
    bus_size = 3'h0;
    wr(`IAOC_IDX_A_SPEED, 32'h000000AA);
    bus_size = `IAOC_HSIZE_WORD;
    bus_bias = 32'h00000100;
    wr(`IAOC_IDX_A_GEAR, 32'h00000055);
    bus(1'b0, `IAOC_IDX_A_GEAR, 32'h00000000, rd);
    check("high_addr_rd", rd, 32'h00000000);
    bus_bias = 32'h00000001;
    wr(`IAOC_IDX_B_SPEED, 32'h00000033);
    bus_bias = 32'h00000000;
    bus(1'b0, `IAOC_IDX_A_SPEED, 32'h00000000, rd);
    check("a_speed_byte_wr", rd, 32'h00000000);
    bus(1'b0, `IAOC_IDX_A_GEAR, 32'h00000000, rd);
    check("a_gear_high_wr", rd, 32'h0000007D);
    bus(1'b0, `IAOC_IDX_B_SPEED, 32'h00000000, rd);
    check("b_speed_misaligned_wr", rd, 32'h00000000);
  endtask

  task automatic t_selectors();
    iaoc_veh_t st [3];
    logic [4:0] sa;
    logic [4:0] sb;
    logic [1:0] f;
    st[0] = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h14, 8'h7F};
    st[1] = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h7D};
    st[2] = '{1'b1, 1'b0, 1'b1, 1'b0, 8'h0F, 8'h7C};
    wr(`IAOC_IDX_A_SPEED, 32'h0000000F);
    wr(`IAOC_IDX_A_GEAR, 32'h0000007D);
    wr(`IAOC_IDX_B_SPEED, 32'h00000005);
    wr(`IAOC_IDX_B_GEAR, 32'h0000007E);
    sw_a <= 1'b1;
    sw_b <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      f = (k == 0) ? 2'h3 : 2'h0;
      wr(`IAOC_IDX_FEAT, {30'h00000000, f});
      for (int s = 0; s < 19; s++) begin
        sa = 5'(s);
        sb = 5'((s + 5) % 17);
        wr(`IAOC_IDX_A_CFG, {27'h0000000, sa});
        wr(`IAOC_IDX_B_CFG, {27'h0000000, sb});
        for (int j = 0; j < 3; j++) begin
          veh <= st[j];
          settle();
          check("aux_a_out", 32'(aux_a_out), 32'(exp_on(sa, st[j], 8'h0F, 8'h7D, f)));
          check("aux_b_out", 32'(aux_b_out), 32'(exp_on(sb, st[j], 8'h05, 8'h7E, f)));
        end
      end
    end
  endtask

  task automatic t_latch_off();
    logic [31:0] rd;
    wr(`IAOC_IDX_A_CFG, 32'h00000107);
    wr(`IAOC_IDX_B_CFG, 32'h00000007);
    veh.engine <= 1'b1;
    settle();
    check("aux_a_out", 32'(aux_a_out), 32'h00000001);
    veh.engine <= 1'b0;
    settle();
    check("aux_a_out", 32'(aux_a_out), 32'h00000000);
    veh.engine <= 1'b1;
    settle();
    check("aux_a_out", 32'(aux_a_out), 32'h00000000);
    check("aux_b_out", 32'(aux_b_out), 32'h00000001);
    bus(1'b0, `IAOC_IDX_STATUS, 32'h00000000, rd);
    check("status", rd & 32'h0000000F, 32'h00000006);
    sw_a <= 1'b0;
    settle();
    sw_a <= 1'b1;
    settle();
    check("aux_a_out", 32'(aux_a_out), 32'h00000001);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
    sw_a = 1'b0;
    sw_b = 1'b0;
    veh = '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h7D};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_refused();
    t_selectors();
    t_latch_off();
    report_and_stop();
  end
endmodule
`default_nettype wire
